// *** flash_map.svh ***
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_PROG_SETUP 8'h40
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hd0
`define CMD_SUSPEND 8'hb0
`define CMD_READ_ID 8'h90

// signature addresses
`define ID_MFG_ADDR 17'h00000
`define ID_DEV_ADDR 17'h00001

// status bit positions
`define ST_DONE_BIT 7
`define ST_ERASE_ERR_BIT 5
`define ST_PROG_ERR_BIT 4
`define ST_VPP_ERR_BIT 3

// timing in ns; cycle counts round up so minimums hold
`define T_CLK_NS 20
`define T_WP_NS 40
`define T_WC_NS 90
`define T_ACC_NS 90
`define T_DF_NS 30
`define T_PS_NS 480
`define CYC_UP(ns) (((ns) + `T_CLK_NS - 1) / `T_CLK_NS)
`define SETUP_CYC 8'h01
`define WP_CYC 8'(`CYC_UP(`T_WP_NS))
`define WC_CYC 8'(`CYC_UP(`T_WC_NS))
`define ACC_CYC 8'(`CYC_UP(`T_ACC_NS))
`define DF_CYC 8'(`CYC_UP(`T_DF_NS))
`define PS_CYC 8'(`CYC_UP(`T_PS_NS))
`define WHOLD_CYC 8'(`WC_CYC - `WP_CYC - `SETUP_CYC)

`define ADDR_W 17
`define DATA_W 8
`define ZERO_ADDR 17'h00000
`define ZERO_DATA 8'h00
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

`endif

// *** flash_pkg.sv ***
`default_nettype none
package flash_pkg;

  typedef enum logic [3:0]
  {
    OP_READ,
    OP_STATUS,
    OP_CLEAR,
    OP_PROGRAM,
    OP_ERASE,
    OP_SUSPEND,
    OP_RESUME,
    OP_READ_ID,
    OP_SIG_HV,
    OP_RESET
  } op_e;

  typedef enum logic [3:0]
  {
    S_DOWN,
    S_PD_WAIT,
    S_IDLE,
    S_PRE,
    S_W1,
    S_W2,
    S_RD,
    S_POLL
  } host_state_e;

  typedef enum logic [1:0]
  {
    M_ARRAY,
    M_STATUS,
    M_ID
  } dev_mode_e;

  typedef enum logic [1:0]
  {
    PH_IDLE,
    PH_SETUP,
    PH_STROBE,
    PH_HOLD
  } cyc_phase_e;

  typedef struct packed {
    cyc_phase_e ph;
    logic [7:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [16:0] addr;
    logic [7:0] dq;
    logic [7:0] rdata;
    logic done;
  } cyc_state_s;

  typedef struct packed {
    host_state_e st;
    dev_mode_e mode;
    logic busy;
    logic [7:0] cmd1;
    logic [7:0] w2;
    logic has_w2;
    logic has_rd;
    logic poll;
    logic [16:0] op_addr;
    logic [16:0] rd_addr;
    logic pwr_n;
    logic hv;
    logic [7:0] cnt;
    logic res_valid;
    logic [7:0] res_data;
  } host_state_s;

endpackage : flash_pkg
`default_nettype wire

// *** flash_cyc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flash_cyc_if;
  logic req;
  logic wr;
  logic [16:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;
  logic busy;

  modport master (output req, output wr, output addr, output wdata,
                  input rdata, input done, input busy);
  modport slave (input req, input wr, input addr, input wdata,
                 output rdata, output done, output busy);
endinterface : flash_cyc_if
`default_nettype wire

// *** flash_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module flash_bus_cycle
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // request side
  flash_cyc_if.slave cyc,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [16:0] flash_addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i
);
  flash_pkg::cyc_state_s s_r;
  flash_pkg::cyc_state_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.ph)
      flash_pkg::PH_IDLE:
        if (cyc.req)
        begin
          s_nxt.wr = cyc.wr;
          s_nxt.addr = cyc.addr;
          s_nxt.dq = cyc.wdata;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = cyc.wr;
          s_nxt.dq_oe = cyc.wr;
          s_nxt.cnt = cyc.wr ? `SETUP_CYC : `ACC_CYC;
          s_nxt.ph = flash_pkg::PH_SETUP;
        end
      flash_pkg::PH_SETUP:
        if (s_r.cnt > `CNT_ONE)
          s_nxt.cnt = s_r.cnt - `CNT_ONE;
        else if (s_r.wr)
        begin
          s_nxt.we_n = 1'b0;
          s_nxt.cnt = `WP_CYC;
          s_nxt.ph = flash_pkg::PH_STROBE;
        end
        else
        begin
          // access time has run out, data is stable
          s_nxt.rdata = dq_i;
          s_nxt.oe_n = 1'b1;
          s_nxt.ce_n = 1'b1;
          s_nxt.cnt = `DF_CYC;
          s_nxt.ph = flash_pkg::PH_HOLD;
        end
      flash_pkg::PH_STROBE:
        if (s_r.cnt > `CNT_ONE)
          s_nxt.cnt = s_r.cnt - `CNT_ONE;
        else
        begin
          // device latches address and data at this rising edge
          s_nxt.we_n = 1'b1;
          s_nxt.cnt = `WHOLD_CYC;
          s_nxt.ph = flash_pkg::PH_HOLD;
        end
      flash_pkg::PH_HOLD:
        if (s_r.cnt > `CNT_ONE)
          s_nxt.cnt = s_r.cnt - `CNT_ONE;
        else
        begin
          // after a read this wait lets the device float the bus
          s_nxt.ce_n = 1'b1;
          s_nxt.dq_oe = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.ph = flash_pkg::PH_IDLE;
        end
      default:
        s_nxt.ph = flash_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.ph <= flash_pkg::PH_IDLE;
      s_r.ce_n <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.we_n <= 1'b1;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign cyc.rdata = s_r.rdata;
  assign cyc.done = s_r.done;
  assign cyc.busy = (s_r.ph != flash_pkg::PH_IDLE);
  assign flash_ce_n = s_r.ce_n;
  assign flash_oe_n = s_r.oe_n;
  assign flash_we_n = s_r.we_n;
  assign flash_addr = s_r.addr;
  assign dq_o = s_r.dq;
  assign dq_oe = s_r.dq_oe;
endmodule : flash_bus_cycle
`default_nettype wire

// *** flash_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module flash_host
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [3:0] op_code,
  input wire logic [16:0] op_addr,
  input wire logic [7:0] op_data,
  input wire logic pd_req,
  // operation result
  output logic res_valid,
  output logic [7:0] res_data,
  output logic res_fail,
  // flash pins
  output logic powerdown_reset_n,
  output logic signature_address_pin_hv,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [16:0] flash_addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i
);
  flash_pkg::host_state_s s_r;
  flash_pkg::host_state_s s_nxt;
  flash_cyc_if cyc ();
  logic issuing;

  flash_bus_cycle u_cycle
  (
    .clk (clk),
    .rst (rst),
    .clk_en (clk_en),
    .cyc (cyc),
    .flash_ce_n (flash_ce_n),
    .flash_oe_n (flash_oe_n),
    .flash_we_n (flash_we_n),
    .flash_addr (flash_addr),
    .dq_o (dq_o),
    .dq_oe (dq_oe),
    .dq_i (dq_i)
  );

  assign issuing = (s_r.st == flash_pkg::S_PRE) ||
                   (s_r.st == flash_pkg::S_W1) ||
                   (s_r.st == flash_pkg::S_W2) ||
                   (s_r.st == flash_pkg::S_RD) ||
                   (s_r.st == flash_pkg::S_POLL);

  // request for the cycle engine, taken while it is idle
  always_comb
  begin
    cyc.req = issuing && !s_r.busy && !cyc.busy;
    cyc.wr = 1'b1;
    cyc.addr = s_r.op_addr;
    cyc.wdata = s_r.cmd1;
    case (s_r.st)
      flash_pkg::S_PRE:
      begin
        cyc.addr = `ZERO_ADDR;
        cyc.wdata = `CMD_READ_ARRAY;
      end
      flash_pkg::S_W2:
        cyc.wdata = s_r.w2;
      flash_pkg::S_RD, flash_pkg::S_POLL:
      begin
        cyc.wr = 1'b0;
        cyc.addr = s_r.rd_addr;
      end
      default:
        cyc.wdata = s_r.cmd1;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.res_valid = 1'b0;
    if (cyc.req)
      s_nxt.busy = 1'b1;
    case (s_r.st)
      flash_pkg::S_DOWN:
        if (!pd_req)
        begin
          s_nxt.pwr_n = 1'b1;
          s_nxt.cnt = `PS_CYC;
          s_nxt.mode = flash_pkg::M_ARRAY;
          s_nxt.st = flash_pkg::S_PD_WAIT;
        end
      flash_pkg::S_PD_WAIT:
        // recovery before the first write strobe
        if (s_r.cnt > `CNT_ONE)
          s_nxt.cnt = s_r.cnt - `CNT_ONE;
        else
          s_nxt.st = flash_pkg::S_IDLE;
      flash_pkg::S_IDLE:
        if (pd_req)
        begin
          s_nxt.pwr_n = 1'b0;
          s_nxt.st = flash_pkg::S_DOWN;
        end
        else if (op_valid)
        begin
          s_nxt.op_addr = op_addr;
          s_nxt.rd_addr = op_addr;
          s_nxt.has_w2 = 1'b0;
          s_nxt.has_rd = 1'b0;
          s_nxt.poll = 1'b0;
          s_nxt.w2 = `CMD_CONFIRM;
          s_nxt.st = flash_pkg::S_W1;
          case (flash_pkg::op_e'(op_code))
            flash_pkg::OP_READ, flash_pkg::OP_SIG_HV:
            begin
              // array read needs array mode; avoid a needless write
              s_nxt.has_rd =
                (flash_pkg::op_e'(op_code) == flash_pkg::OP_SIG_HV);
              // keep high voltage off the pin during the FFH write
              s_nxt.hv = s_nxt.has_rd && (s_r.mode == flash_pkg::M_ARRAY);
              if (s_nxt.has_rd)
                s_nxt.rd_addr = op_addr[0] ? `ID_DEV_ADDR
                                           : `ID_MFG_ADDR;
              s_nxt.st = (s_r.mode == flash_pkg::M_ARRAY) ?
                         flash_pkg::S_RD : flash_pkg::S_PRE;
            end
            flash_pkg::OP_STATUS:
            begin
              s_nxt.cmd1 = `CMD_READ_STATUS;
              s_nxt.has_rd = 1'b1;
              s_nxt.mode = flash_pkg::M_STATUS;
            end
            flash_pkg::OP_CLEAR:
              s_nxt.cmd1 = `CMD_CLEAR_STATUS;
            flash_pkg::OP_PROGRAM:
            begin
              s_nxt.cmd1 = `CMD_PROG_SETUP;
              s_nxt.w2 = op_data;
              s_nxt.has_w2 = 1'b1;
              s_nxt.poll = 1'b1;
              s_nxt.mode = flash_pkg::M_STATUS;
            end
            flash_pkg::OP_ERASE:
            begin
              s_nxt.cmd1 = `CMD_ERASE_SETUP;
              s_nxt.has_w2 = 1'b1;
              s_nxt.poll = 1'b1;
              s_nxt.mode = flash_pkg::M_STATUS;
            end
            flash_pkg::OP_SUSPEND:
            begin
              s_nxt.cmd1 = `CMD_SUSPEND;
              s_nxt.poll = 1'b1;
              s_nxt.mode = flash_pkg::M_STATUS;
            end
            flash_pkg::OP_RESUME:
            begin
              s_nxt.cmd1 = `CMD_CONFIRM;
              s_nxt.mode = flash_pkg::M_STATUS;
            end
            flash_pkg::OP_READ_ID:
            begin
              s_nxt.cmd1 = `CMD_READ_ID;
              s_nxt.has_rd = 1'b1;
              s_nxt.rd_addr = op_addr[0] ? `ID_DEV_ADDR
                                         : `ID_MFG_ADDR;
              s_nxt.mode = flash_pkg::M_ID;
            end
            default:
            begin
              s_nxt.cmd1 = `CMD_READ_ARRAY;
              s_nxt.mode = flash_pkg::M_ARRAY;
            end
          endcase
        end
      default:
        if (cyc.done)
        begin
          s_nxt.busy = 1'b0;
          case (s_r.st)
            flash_pkg::S_PRE:
            begin
              s_nxt.hv = s_r.has_rd;
              s_nxt.mode = flash_pkg::M_ARRAY;
              s_nxt.st = flash_pkg::S_RD;
            end
            flash_pkg::S_W1, flash_pkg::S_W2:
              // one or two writes, then read, poll or finish
              if (s_r.st == flash_pkg::S_W1 && s_r.has_w2)
                s_nxt.st = flash_pkg::S_W2;
              else if (s_r.has_rd)
                s_nxt.st = flash_pkg::S_RD;
              else if (s_r.poll)
                s_nxt.st = flash_pkg::S_POLL;
              else
              begin
                s_nxt.res_valid = 1'b1;
                s_nxt.res_data = `ZERO_DATA;
                s_nxt.st = flash_pkg::S_IDLE;
              end
            flash_pkg::S_POLL:
              // no timeout: erase can run for many seconds
              if (cyc.rdata[`ST_DONE_BIT])
              begin
                s_nxt.res_valid = 1'b1;
                s_nxt.res_data = cyc.rdata;
                s_nxt.st = flash_pkg::S_IDLE;
              end
            default:
            begin
              s_nxt.res_valid = 1'b1;
              s_nxt.res_data = cyc.rdata;
              s_nxt.hv = 1'b0;
              s_nxt.st = flash_pkg::S_IDLE;
            end
          endcase
        end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.st <= flash_pkg::S_DOWN;
      s_r.mode <= flash_pkg::M_ARRAY;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign op_ready = (s_r.st == flash_pkg::S_IDLE) && !pd_req;
  assign res_valid = s_r.res_valid;
  assign res_data = s_r.res_data;
  assign res_fail = s_r.res_valid && s_r.poll &&
                    (s_r.res_data[`ST_ERASE_ERR_BIT] ||
                     s_r.res_data[`ST_PROG_ERR_BIT] ||
                     s_r.res_data[`ST_VPP_ERR_BIT]);
  assign powerdown_reset_n = s_r.pwr_n;
  assign signature_address_pin_hv = s_r.hv;
endmodule : flash_host
`default_nettype wire

// *** flash_host_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flash pins
  input wire logic powerdown_reset_n,
  input wire logic signature_address_pin_hv,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [16:0] flash_addr,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  // result
  input wire logic res_valid,
  input wire logic res_fail
);
  logic [7:0] up_cnt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since leaving deep power-down, saturating
  always_ff @(posedge clk or posedge rst)
    if (rst)
      up_cnt_r <= 8'h00;
    else if (!powerdown_reset_n)
      up_cnt_r <= 8'h00;
    else if (up_cnt_r != 8'hff)
      up_cnt_r <= up_cnt_r + 8'h01;

  sequence we_strobe;
    !flash_we_n ##1 !flash_we_n ##1 flash_we_n;
  endsequence
  sequence held_write;
    dq_oe && !flash_ce_n && $stable(dq_o) && $stable(flash_addr);
  endsequence
  sequence read_open;
    !flash_ce_n ##1 (!flash_oe_n && $stable(flash_addr))[*4];
  endsequence

  a_we_width: assert property ($fell(flash_we_n) |-> we_strobe)
    else $error("write strobe width wrong");
  a_write_held: assert property (
    !flash_we_n || $rose(flash_we_n) |-> held_write)
    else $error("write data or address moved");
  a_no_clash: assert property (
    !flash_oe_n |-> !dq_oe && flash_we_n)
    else $error("host drives bus during read");
  a_read_time: assert property ($fell(flash_oe_n) |-> read_open)
    else $error("read cycle too short");
  a_float_gap: assert property ($rose(flash_oe_n) |-> !dq_oe[*3])
    else $error("bus driven before float time");
  a_pd_quiet: assert property (
    !powerdown_reset_n |-> flash_ce_n && flash_we_n && !dq_oe)
    else $error("activity in deep power-down");
  a_pd_recover: assert property (
    !flash_we_n |-> up_cnt_r >= 8'h18)
    else $error("write too soon after power-down exit");
  a_hv_no_write: assert property (
    signature_address_pin_hv |-> flash_we_n)
    else $error("write while signature voltage applied");
  a_hv_addr: assert property (
    signature_address_pin_hv && !flash_oe_n |-> flash_addr[16:1] == 16'h0000)
    else $error("signature read with high address bits");
  a_fail_strobe: assert property (
    res_fail |-> res_valid ##1 !res_valid)
    else $error("fail flag outside one-cycle result");
endmodule : flash_host_monitor

bind flash_host flash_host_monitor u_monitor
(
  .clk(clk), .rst(rst), .powerdown_reset_n(powerdown_reset_n),
  .signature_address_pin_hv(signature_address_pin_hv),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_addr(flash_addr), .dq_o(dq_o),
  .dq_oe(dq_oe), .res_valid(res_valid), .res_fail(res_fail)
);
`default_nettype wire

// *** flash_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
#(
  parameter logic [7:0] MFG_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'ha6, // arbitrary value
  parameter int PROG_NS = 15000,
  // erase kept far below real time so runs stay short
  parameter int ERASE_NS = 30000
)
(
  // control pins
  input wire logic powerdown_reset_n,
  input wire logic hv,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // address and data
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:131071];
  logic [1:0] mode_r;
  logic [7:0] pend_r, err_r, srl_r, rd, last_r;
  logic susp_r, drive;
  time done_t;

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
    {mode_r, pend_r, err_r, srl_r, last_r, susp_r} = '0;
    done_t = 0;
  end

  always @(negedge powerdown_reset_n)
  begin
    mode_r = 2'h0;
    pend_r = 8'h00;
  end

  // status is latched as the read opens, so a poll sees a fresh value
  always @(negedge oe_n or negedge ce_n)
    srl_r = {$time >= done_t, susp_r, err_r[5:3], 3'h0};

  always @*
    if (hv || mode_r == 2'h2)
      rd = addr[0] ? DEV_ID : MFG_ID;
    else if (mode_r == 2'h1)
      rd = srl_r;
    else
      rd = mem[addr];

  assign drive = powerdown_reset_n && !ce_n && !oe_n && we_n;
  // a released bus shows the inverse, never a kind stale value
  always @*
    if (drive)
      last_r = rd;
  assign dout = drive ? rd : ~last_r;

  always @(posedge we_n)
  begin
    if (powerdown_reset_n && !ce_n && oe_n)
    begin
      if (pend_r == 8'h40 || pend_r == 8'h10)
      begin
        if ((mem[addr] & din) != din)
          err_r[4] = 1'b1;
        mem[addr] = mem[addr] & din;
        done_t = $time + PROG_NS;
        pend_r = 8'h00;
      end
      else if (pend_r == 8'h20 && din == 8'hd0)
      begin
        // no unlock voltage is modelled, so the boot block stays locked
        if (addr[16:13] == 4'hf)
          err_r[5] = 1'b1;
        else
        begin
          foreach (mem[i])
            if (i[16:13] == addr[16:13])
              mem[i] = 8'hff;
          done_t = $time + ERASE_NS;
        end
        pend_r = 8'h00;
      end
      else
      begin
        pend_r = 8'h00;
        case (din)
          8'hff: mode_r = 2'h0;
          8'h70: mode_r = 2'h1;
          8'h50: err_r = 8'h00;
          8'h40, 8'h10, 8'h20:
          begin
            pend_r = din;
            mode_r = 2'h1;
          end
          8'hb0:
          begin
            susp_r = 1'b1;
            mode_r = 2'h1;
          end
          8'hd0: susp_r = 1'b0;
          8'h90: mode_r = 2'h2;
          default: ;
        endcase
      end
    end
  end
endmodule : flash_dev_model
`default_nettype wire

// *** test_flash_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_host;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [16:0] op_addr = 17'h00000;
  logic [7:0] op_data = 8'h00;
  logic pd_req = 1'b0;
  logic clk_en = 1'b1;
  logic op_ready, res_valid, res_fail, pd_n, hv, ce_n, oe_n, we_n, dq_oe;
  logic gfail;
  logic [16:0] faddr;
  logic [7:0] res_data, dq_o, dq_dev, dq_i, got;
  int error_cnt = 0;
  int checks_done = 0;

  assign dq_i = dq_oe ? dq_o : dq_dev;
  always #10 clk = ~clk;

  flash_host dut
  (
    .clk(clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr),
    .op_data(op_data), .pd_req(pd_req), .res_valid(res_valid),
    .res_data(res_data), .res_fail(res_fail), .powerdown_reset_n(pd_n),
    .signature_address_pin_hv(hv), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(faddr), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i)
  );

  flash_dev_model dev
  (
    .powerdown_reset_n(pd_n), .hv(hv), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(faddr), .din(dq_o), .dout(dq_dev)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic op_chk(input logic [3:0] c, input logic [16:0] a,
                        input logic [7:0] d, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_addr <= a;
    op_data <= d;
    do @(negedge clk); while (op_ready !== 1'b1 && ++n < 3000);
    @(posedge clk);
    op_valid <= 1'b0;
    do @(negedge clk); while (res_valid !== 1'b1 && ++n < 4000);
    got = res_data;
    gfail = res_fail;
    if (res_valid !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: no result", $time);
    end
    check(got, exp);
  endtask : op_chk

  task automatic t_program;
    op_chk(flash_pkg::OP_PROGRAM, 17'h1abcd, 8'h5a, 8'h80);
    check({7'h00, gfail}, 8'h00);
    op_chk(flash_pkg::OP_READ, 17'h1abcd, 8'h00, 8'h5a);
    // raising bits cannot program, so the device flags it
    op_chk(flash_pkg::OP_PROGRAM, 17'h1abcd, 8'hff, 8'h90);
    check({7'h00, gfail}, 8'h01);
    op_chk(flash_pkg::OP_STATUS, 17'h00000, 8'h00, 8'h90);
    op_chk(flash_pkg::OP_CLEAR, 17'h00000, 8'h00, 8'h00);
    op_chk(flash_pkg::OP_STATUS, 17'h00000, 8'h00, 8'h80);
  endtask : t_program

  task automatic t_ident;
    op_chk(flash_pkg::OP_READ_ID, 17'h00000, 8'h00, 8'h5a);
    op_chk(flash_pkg::OP_READ_ID, 17'h00001, 8'h00, 8'ha6);
    op_chk(flash_pkg::OP_SIG_HV, 17'h00000, 8'h00, 8'h5a);
    op_chk(flash_pkg::OP_READ, 17'h1abcd, 8'h00, 8'h5a);
    op_chk(flash_pkg::OP_SIG_HV, 17'h00000, 8'h00, 8'h5a);
    op_chk(flash_pkg::OP_SIG_HV, 17'h00001, 8'h00, 8'ha6);
  endtask : t_ident

  task automatic t_erase;
    op_chk(flash_pkg::OP_PROGRAM, 17'h04000, 8'h00, 8'h80);
    op_chk(flash_pkg::OP_ERASE, 17'h04000, 8'h00, 8'h80);
    op_chk(flash_pkg::OP_READ, 17'h04000, 8'h00, 8'hff);
    op_chk(flash_pkg::OP_READ, 17'h1abcd, 8'h00, 8'h5a);
    op_chk(flash_pkg::OP_ERASE, 17'h1e000, 8'h00, 8'ha0);
    check({7'h00, gfail}, 8'h01);
    op_chk(flash_pkg::OP_CLEAR, 17'h00000, 8'h00, 8'h00);
  endtask : t_erase

  task automatic t_misc;
    op_chk(flash_pkg::OP_SUSPEND, 17'h00000, 8'h00, 8'hc0);
    op_chk(flash_pkg::OP_RESUME, 17'h00000, 8'h00, 8'h00);
    op_chk(flash_pkg::OP_RESET, 17'h00000, 8'h00, 8'h00);
    op_chk(4'hf, 17'h00000, 8'h00, 8'h00);
    op_chk(flash_pkg::OP_READ, 17'h1abcd, 8'h00, 8'h5a);
  endtask : t_misc

  task automatic t_powerdown;
    int n;
    n = 0;
    op_chk(flash_pkg::OP_STATUS, 17'h00000, 8'h00, 8'h80);
    @(posedge clk);
    pd_req <= 1'b1;
    do @(negedge clk); while (pd_n !== 1'b0 && ++n < 50);
    check({5'h00, pd_n, ce_n, dq_oe}, 8'h02);
    repeat (4) @(posedge clk);
    clk_en <= 1'b0;
    pd_req <= 1'b0;
    // with the enable low the host must stay in power-down
    repeat (3) @(negedge clk);
    check({7'h00, pd_n}, 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    // host trusts array mode at exit, so the device must reset itself
    op_chk(flash_pkg::OP_READ, 17'h1abcd, 8'h00, 8'h5a);
  endtask : t_powerdown

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_program();
    t_ident();
    t_erase();
    t_misc();
    t_powerdown();
    wrap_up();
  end

  initial
  begin
    // a full run is a few thousand cycles; this leaves ample margin
    #400000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : test_flash_host
`default_nettype wire
